// File: rtl/pbt_top.sv
// Strobe preamble, training and postamble logic with bank-group tracking.
`timescale 1ns/1ps
`include "pbt_cfg.svh"
module pbt_top
    import pbt_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Link pins from the controller
    input  wire logic        ck_pin,
    input  wire logic [2:0]  cmd_pin,
    input  wire logic [1:0]  bg_pin,
    input  wire logic [1:0]  ba_pin,
    input  wire logic [12:0] addr_pin,
    // Configuration
    input  wire logic        org_x16,
    input  wire logic        mpr_access,
    input  wire logic [1:0]  mpr_page,
    input  wire logic [4:0]  cas_lat,
    input  wire logic [4:0]  cas_wr_lat,
    input  wire logic        burst_chop,
    input  wire logic        wcrc_en,
    // Strobe and data pins
    output logic             dqs_t_o,
    output logic             dqs_c_o,
    output logic             dqs_oe,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    // Status
    output logic             wpre_long,
    output logic             rpre_long,
    output logic             train_on,
    output logic             wr_window,
    output logic             gap_err,
    output logic [15:0]      open_banks
);

    pbt_link_if lk ();
    pbt_top_s   st;
    pbt_top_s   next_st;
    logic       mrs4;
    logic       rd_start;
    logic       wr_start;
    logic       is_col;
    logic [4:0] half;

    pbt_sampler u_sampler
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pins    ({addr_pin, ba_pin, bg_pin, cmd_pin, ck_pin}),
        .org_x16 (org_x16),
        .lk      (lk)
    );

    // ======================================================================
    // Latency sequencer, shared by the read strobe and the write window
    // A new command is taken only from idle or on the last burst clock, where it
    // restarts the full latency wait; a command during wait or preamble is dropped.
    function automatic pbt_seq_s seq_step(input pbt_seq_s s, input logic rise,
                                          input logic start, input logic [4:0] lat,
                                          input logic pre2, input logic [4:0] hb);
        pbt_seq_s   r;
        logic [4:0] pre;
        r   = s;
        pre = pre2 ? `PBT_PRE_LONG : `PBT_PRE_SHORT;
        if (rise)
        begin
            case (s.st)
                PBT_S_IDLE:
                    if (start)
                    begin
                        r.st  = PBT_S_WAIT;
                        r.cnt = lat - pre;
                    end
                PBT_S_WAIT:
                    if (s.cnt <= 5'h01)
                    begin
                        r.st  = PBT_S_PREAM;
                        r.cnt = pre;
                    end
                    else
                        r.cnt = s.cnt - 5'h01;
                PBT_S_PREAM:
                    if (s.cnt == 5'h01)
                    begin
                        r.st  = PBT_S_BURST;
                        r.cnt = hb;
                    end
                    else
                        r.cnt = s.cnt - 5'h01;
                PBT_S_BURST:
                    if (s.cnt != 5'h01)
                        r.cnt = s.cnt - 5'h01;
                    else if (start)
                    begin
                        r.st  = PBT_S_WAIT;
                        r.cnt = lat - pre;
                    end
                    else
                        r.st  = PBT_S_IDLE;
                default:
                    r.st = PBT_S_IDLE;
            endcase
        end
        return r;
    endfunction

    // ======================================================================
    // Mode, spacing and strobe state
    always_comb
    begin
        next_st         = st;
        next_st.gap_err = 1'b0;
        half     = burst_chop ? `PBT_HALF_BC4 : `PBT_HALF_BL8;
        mrs4     = lk.ck_rise && lk.cmd == PBT_MRS && lk.mr_sel == `PBT_MR4_SEL;
        is_col   = lk.ck_rise && (lk.cmd == PBT_RD || lk.cmd == PBT_WR);
        // While training only a page-0 register read releases the strobes.
        rd_start = lk.cmd == PBT_RD && (!st.train || mpr_page == `PBT_MPR_PAGE0);
        wr_start = lk.cmd == PBT_WR;
        if (mrs4)
        begin
            next_st.wpre2 = lk.addr[`PBT_WPRE_BIT];
            next_st.rpre2 = lk.addr[`PBT_RPRE_BIT];
            next_st.train = lk.addr[`PBT_TRAIN_BIT];
        end
        // Forbidden gaps are the controller's to avoid; flagging them costs little.
        if (is_col)
        begin
            next_st.gap_err  = st.col_seen &&
                ((st.col_gap == `PBT_GAP_FORBID && (st.rpre2 || (st.wpre2 && !wcrc_en)))
                 || (st.col_gap == `PBT_GAP_FORBID_C && st.wpre2 && wcrc_en));
            next_st.col_gap  = 5'h01;
            next_st.col_seen = 1'b1;
        end
        else if (lk.ck_rise && st.col_gap != `PBT_GAP_MAX)
            next_st.col_gap = st.col_gap + 5'h01;
        if (lk.ck_rise && lk.cmd == PBT_ACT)
            next_st.open_banks[lk.bank] = 1'b1;
        if (lk.ck_rise && lk.cmd == PBT_PRE)
            next_st.open_banks[lk.bank] = 1'b0;
        next_st.rd = seq_step(st.rd, lk.ck_rise, rd_start, cas_lat, st.rpre2, half);
        // The write window leans on the controller keeping a half-clock postamble.
        next_st.wr = seq_step(st.wr, lk.ck_rise, wr_start, cas_wr_lat, st.wpre2, half);
        next_st.wr_window = next_st.wr.st == PBT_S_PREAM || next_st.wr.st == PBT_S_BURST;
        // The strobe follows the link clock in the burst, so the last falling edge
        // leaves it low for the final half clock before release.
        next_st.dqs_t  = next_st.rd.st == PBT_S_BURST ? lk.ck_level : 1'b0;
        next_st.dqs_c  = ~next_st.dqs_t;
        // Unless training with mpr_access set, the strobe stays released through the latency wait, so the preamble is
        // exactly the programmed length rather than the whole wait.
        next_st.dqs_oe = next_st.rd.st == PBT_S_PREAM || next_st.rd.st == PBT_S_BURST
            || (next_st.train && mpr_access);
        next_st.dq_oe  = next_st.train && mpr_access;
        next_st.dq     = `PBT_DQ_QUIET;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign dqs_t_o    = st.dqs_t;
    assign dqs_c_o    = st.dqs_c;
    assign dqs_oe     = st.dqs_oe;
    assign dq_o       = st.dq;
    assign dq_oe      = st.dq_oe;
    assign wpre_long  = st.wpre2;
    assign rpre_long  = st.rpre2;
    assign train_on   = st.train;
    assign wr_window  = st.wr_window;
    assign gap_err    = st.gap_err;
    assign open_banks = st.open_banks;

    // ======================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_mr4_write;
        lk.ck_rise && lk.cmd == PBT_MRS && lk.mr_sel == `PBT_MR4_SEL;
    endsequence

    sequence s_train_entry;
        s_mr4_write ##0 lk.addr[`PBT_TRAIN_BIT] && mpr_access;
    endsequence

    chk_wpre_select: assert property (s_mr4_write |=> wpre_long == $past(lk.addr[12]))
        else $error("write preamble length not taken from bit 12");
    chk_rpre_select: assert property (s_mr4_write |=> rpre_long == $past(lk.addr[11]))
        else $error("read preamble length not taken from bit 11");
    chk_pre_independent: assert property (
        s_mr4_write ##0 (lk.addr[12] != lk.addr[11]) |=> wpre_long != rpre_long)
        else $error("write and read preamble settings are coupled");
    chk_train_hold: assert property (train_on && !mrs4 |=> train_on)
        else $error("training left without a mode register write");
    chk_train_quiet: assert property (
        s_train_entry ##1 mpr_access |-> dqs_oe && dq_oe && dq_o == `PBT_DQ_QUIET)
        else $error("training entry did not drive strobes and quiet data");
    chk_train_strobe_low: assert property (
        train_on && mpr_access && st.rd.st != PBT_S_BURST |-> dqs_oe && !dqs_t_o && dqs_c_o)
        else $error("strobe not parked low during training");
    chk_rd_preamble_len: assert property (
        st.rd.st == PBT_S_WAIT && st.rd.cnt == 5'h01 && lk.ck_rise |=>
        st.rd.st == PBT_S_PREAM && st.rd.cnt == (rpre_long ? `PBT_PRE_LONG : `PBT_PRE_SHORT))
        else $error("read preamble length wrong");
    chk_rd_wait_quiet: assert property (
        st.rd.st == PBT_S_WAIT && !train_on |-> !dqs_oe)
        else $error("read strobe driven before the preamble");
    chk_rd_postamble: assert property (
        st.rd.st == PBT_S_BURST && st.rd.cnt == 5'h01 && !lk.ck_level && !lk.ck_rise |=>
        dqs_oe && !dqs_t_o)
        else $error("read postamble not held low");
    chk_gap_flag: assert property (
        is_col && st.col_seen && st.rpre2 && st.col_gap == `PBT_GAP_FORBID |=> gap_err)
        else $error("forbidden five-clock column gap not flagged");

endmodule // pbt_top

// File: rtl/pbt_cfg.svh
// Constants for the strobe preamble and bank-group timing block.
//
// Behaviour
// - Write and read preamble lengths are set independently of each other.
// - Mode register 4 bit 12 picks one- or two-clock write preamble.
// - Mode register 4 bit 11 picks one- or two-clock read preamble.
// - Training is entered by setting mode register 4 bit 10, left by clearing.
// - In training the strobes are driven valid and all data lines held high; the code does so only while mpr_access is set.
// - Training holds strobe low until a page-0 read, then toggles after CL.
// - Device ends every read strobe burst with a half-clock postamble.
// - Four groups of four banks for x4/x8, two groups for x16.
`ifndef PBT_CFG_SVH
`define PBT_CFG_SVH

// ==========================================================================
// Mode register fields
`define PBT_MR4_SEL      3'h4
`define PBT_WPRE_BIT     12
`define PBT_RPRE_BIT     11
`define PBT_TRAIN_BIT    10
`define PBT_MPR_PAGE0    2'h0

// ==========================================================================
// Burst, preamble and gap lengths in link clocks, and the quiet data pattern
`define PBT_PRE_SHORT    5'h01
`define PBT_PRE_LONG     5'h02
`define PBT_HALF_BL8     5'h04
`define PBT_HALF_BC4     5'h02
`define PBT_GAP_FORBID   5'h05
`define PBT_GAP_FORBID_C 5'h06
`define PBT_GAP_MAX      5'h1F
`define PBT_DQ_QUIET     8'hFF

`endif

// File: rtl/pbt_pkg.sv
// Types shared by the strobe preamble and bank-group timing block.
package pbt_pkg;

    typedef enum logic [2:0]
    {
        PBT_NOP = 3'b000,
        PBT_ACT = 3'b001,
        PBT_RD  = 3'b010,
        PBT_WR  = 3'b011,
        PBT_MRS = 3'b100,
        PBT_PRE = 3'b101
    } pbt_cmd_e;

    typedef enum logic [1:0]
    {
        PBT_S_IDLE  = 2'b00,
        PBT_S_WAIT  = 2'b01,
        PBT_S_PREAM = 2'b10,
        PBT_S_BURST = 2'b11
    } pbt_seq_e;

    typedef struct packed
    {
        pbt_seq_e   st;
        logic [4:0] cnt;
    } pbt_seq_s;

    typedef struct packed
    {
        logic [12:0] addr;
        logic [1:0]  ba;
        logic [1:0]  bg;
        logic [2:0]  cmd;
        logic        ck;
    } pbt_pins_s;

    typedef struct packed
    {
        pbt_pins_s   s1;
        pbt_pins_s   s2;
        logic        ck_prev;
        logic        rise;
        logic        ck_level;
        pbt_cmd_e    cmd;
        logic [1:0]  grp;
        logic [3:0]  bank;
        logic [2:0]  mr_sel;
        logic [12:0] addr;
    } pbt_smp_s;

    typedef struct packed
    {
        logic        wpre2;
        logic        rpre2;
        logic        train;
        logic [4:0]  col_gap;
        logic        col_seen;
        logic        gap_err;
        logic [15:0] open_banks;
        pbt_seq_s    rd;
        pbt_seq_s    wr;
        logic        dqs_t;
        logic        dqs_c;
        logic        dqs_oe;
        logic [7:0]  dq;
        logic        dq_oe;
        logic        wr_window;
    } pbt_top_s;

endpackage

// File: rtl/pbt_link_if.sv
// Sampled link clock and decoded command passed from the sampler to the core.
`timescale 1ns/1ps
interface pbt_link_if;
    import pbt_pkg::*;

    logic        ck_rise;
    logic        ck_level;
    pbt_cmd_e    cmd;
    logic [1:0]  grp;
    logic [3:0]  bank;
    logic [2:0]  mr_sel;
    logic [12:0] addr;

    modport src (output ck_rise, ck_level, cmd, grp, bank, mr_sel, addr);
    modport dst (input ck_rise, ck_level, cmd, grp, bank, mr_sel, addr);
endinterface

// File: rtl/pbt_sampler.sv
// Synchronises the link pins, finds link clock rises and decodes bank groups.
`timescale 1ns/1ps
module pbt_sampler
    import pbt_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Link pins
    input  wire pbt_pins_s   pins,
    input  wire logic        org_x16,
    // Decoded link
    pbt_link_if.src          lk
);

    pbt_smp_s st;
    pbt_smp_s next_st;

    // ======================================================================
    // Sampling
    always_comb
    begin
        next_st          = st;
        next_st.s1       = pins;
        next_st.s2       = st.s1;
        next_st.ck_prev  = st.s2.ck;
        next_st.rise     = st.s2.ck & ~st.ck_prev;
        next_st.ck_level = st.s2.ck;
        next_st.cmd      = pbt_cmd_e'(st.s2.cmd);
        next_st.addr     = st.s2.addr;
        next_st.mr_sel   = {st.s2.bg[0], st.s2.ba};
        // A x16 part has only one group bit, so the upper group bit is ignored.
        if (org_x16)
        begin
            next_st.grp  = {1'b0, st.s2.bg[0]};
            next_st.bank = {1'b0, st.s2.bg[0], st.s2.ba};
        end
        else
        begin
            next_st.grp  = st.s2.bg;
            next_st.bank = {st.s2.bg, st.s2.ba};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign lk.ck_rise  = st.rise;
    assign lk.ck_level = st.ck_level;
    assign lk.cmd      = st.cmd;
    assign lk.grp      = st.grp;
    assign lk.bank     = st.bank;
    assign lk.mr_sel   = st.mr_sel;
    assign lk.addr     = st.addr;

    chk_bank_group_map: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) && $stable(org_x16) |->
        (org_x16 ? (st.bank == {1'b0, $past(st.s2.bg[0]), $past(st.s2.ba)})
                 : (st.bank == {$past(st.s2.bg), $past(st.s2.ba)})))
        else $error("bank group decode does not match the organisation");

endmodule // pbt_sampler

// File: dv/pbt_ctrl_model.sv
// Controller model that runs the link clock and drives commands on it.
`timescale 1ns/1ps
module pbt_ctrl_model
    import pbt_pkg::*;
(
    // Link pins
    output logic        ck_pin,
    output logic [2:0]  cmd_pin,
    output logic [1:0]  bg_pin,
    output logic [1:0]  ba_pin,
    output logic [12:0] addr_pin
);
    // The 1 ns offset keeps link edges clear of the system clock edges.
    initial
    begin
        ck_pin = 1'b0;
        cmd_pin = PBT_NOP;
        bg_pin = 2'h0;
        ba_pin = 2'h0;
        addr_pin = 13'h0000;
        #1;
        forever #32 ck_pin = ~ck_pin;
    end

    // ======================================================================
    // Command issue
    // Pins change at the falling link edge so they are steady at the rise.
    // Gaps are the caller's choice; illegal ones are asked for on purpose.
    task automatic issue(input logic [2:0] c, input logic [1:0] g, input logic [1:0] b,
                         input logic [12:0] a, input int gap);
        @(negedge ck_pin);
        cmd_pin = c;
        bg_pin = g;
        ba_pin = b;
        addr_pin = a;
        @(negedge ck_pin);
        cmd_pin = PBT_NOP;
        bg_pin = ~g;
        ba_pin = ~b;
        addr_pin = ~a;
        repeat (gap - 2) @(negedge ck_pin);
    endtask
endmodule // pbt_ctrl_model

// File: dv/tb.sv
// Self-checking bench for the strobe preamble and bank-group timing block.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); \
        end \
    end
module tb
    import pbt_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ck_pin, org_x16, mpr_access, burst_chop, wcrc_en;
    logic [2:0]  cmd_pin;
    logic [1:0]  bg_pin, ba_pin, mpr_page;
    logic [12:0] addr_pin;
    logic [4:0]  cas_lat, cas_wr_lat;
    logic        dqs_t_o, dqs_c_o, dqs_oe, dq_oe, wpre_long, rpre_long, train_on;
    logic        wr_window, gap_err, t_prev, oe_prev, rd_chk;
    logic [7:0]  dq_o;
    logic [15:0] open_banks, acc, bank_prev, e16;
    logic [2:0]  mode_q[$];
    logic [11:0] rd_q[$];
    logic [15:0] bank_q[$];
    logic [2:0]  mode_prev, cur, e3;
    logic [11:0] e12;
    logic [3:0]  b;
    int          err_count, check_count, cyc, pre_n, rise_n, post_n, t_rises, ge_n, ww_n, off;
    // Rows: preamble mode, crc, read, gap, expected flag count.
    logic [8:0]  gt[6] = '{9'b010_0_1_101_1, 9'b010_0_1_100_0, 9'b100_0_0_101_1,
                            9'b100_1_0_101_0, 9'b100_1_0_110_1, 9'b000_0_0_101_0};

    pbt_ctrl_model u_pbt_ctrl_model (.ck_pin, .cmd_pin, .bg_pin, .ba_pin, .addr_pin);
    pbt_top u_pbt_top (.ref_clk, .sys_rst, .ck_pin, .cmd_pin, .bg_pin, .ba_pin, .addr_pin,
        .org_x16, .mpr_access, .mpr_page, .cas_lat, .cas_wr_lat, .burst_chop, .wcrc_en,
        .dqs_t_o, .dqs_c_o, .dqs_oe, .dq_o, .dq_oe, .wpre_long, .rpre_long, .train_on,
        .wr_window, .gap_err, .open_banks);

    always #4 ref_clk = ~ref_clk;

    // ======================================================================
    // Output watcher
    // Outputs are sampled at the falling edge, where they are settled.
    always @(negedge ref_clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            err_count++;
            summarize();
        end
        if (gap_err) ge_n++;
        if (wr_window) ww_n++;
        if (dqs_t_o && !t_prev) t_rises++;
        if (!sys_rst && {wpre_long, rpre_long, train_on} !== mode_prev)
        begin
            e3 = mode_q.size() ? mode_q.pop_front() : 'x;
            `CHK({wpre_long, rpre_long, train_on}, e3)
        end
        if (!sys_rst && open_banks !== bank_prev)
        begin
            e16 = bank_q.size() ? bank_q.pop_front() : 'x;
            `CHK(open_banks, e16)
        end
        if (dqs_oe)
        begin
            if (dqs_t_o && !t_prev) rise_n++;
            if (rise_n == 0) pre_n++;
            post_n = dqs_t_o ? 0 : post_n + 1;
        end
        else if (oe_prev && !sys_rst)
        begin
            e12 = rd_q.size() ? rd_q.pop_front() : 'x;
            if (rd_chk)
                `CHK({4'((pre_n + 4) / 8), 4'(rise_n), 4'((post_n + 2) / 4)}, e12)
            pre_n = 0;
            rise_n = 0;
            post_n = 0;
        end
        t_prev = dqs_t_o;
        oe_prev = dqs_oe;
        mode_prev = {wpre_long, rpre_long, train_on};
        bank_prev = open_banks;
    end

    task automatic mr4(input logic [2:0] m);
        mode_q.push_back(m);
        u_pbt_ctrl_model.issue(PBT_MRS, 2'h1, 2'h0, {m, 10'h000}, 8);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ======================================================================
    // Main sequence
    // The bench stands for a 2400 or faster bin, so long preambles are legal.
    initial
    begin
        {org_x16, mpr_access, burst_chop, wcrc_en, rd_chk} = 5'h00;
        mpr_page = 2'h0;
        cas_lat = 5'h08;
        cas_wr_lat = 5'h09;
        void'($urandom(17));
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK({dqs_oe, dq_oe, wpre_long, rpre_long, train_on}, 5'h00)
        `CHK({wr_window, gap_err, open_banks, dq_o}, 26'h000_00FF)
        $display("test reset done");
        mr4(3'b100);
        mr4(3'b110);
        mr4(3'b010);
        mr4(3'b000);
        $display("test modes done");
        rd_chk = 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            if (r == 1) mr4(3'b010);
            for (int bc = 0; bc < 2; bc++)
            begin
                @(negedge ref_clk);
                burst_chop = bc[0];
                cas_lat = 5'(6 + $urandom % 4);
                rd_q.push_back({4'(r + 1), bc ? 4'h2 : 4'h4, 4'h1});
                u_pbt_ctrl_model.issue(PBT_RD, 2'(bc), 2'h0, 13'h0000, 20);
            end
        end
        rd_chk = 1'b0;
        $display("test reads done");
        burst_chop = 1'b0;
        for (int w = 0; w < 2; w++)
        begin
            mr4(w ? 3'b100 : 3'b000);
            @(negedge ref_clk);
            cas_wr_lat = w ? 5'h0A : 5'h09;
            ww_n = 0;
            // The long gap also covers the write-to-read turnaround before the next read.
            u_pbt_ctrl_model.issue(PBT_WR, 2'h0, 2'h0, 13'h0000, 24);
            `CHK((ww_n + 4) / 8, w + 5)
        end
        $display("test writes done");
        cur = 3'b100;
        foreach (gt[i])
        begin
            if (gt[i][8:6] != cur) mr4(gt[i][8:6]);
            cur = gt[i][8:6];
            @(negedge ref_clk);
            wcrc_en = gt[i][5];
            ge_n = 0;
            u_pbt_ctrl_model.issue(gt[i][4] ? PBT_RD : PBT_WR, 2'h0, 2'h0, 13'h0000, gt[i][3:1]);
            u_pbt_ctrl_model.issue(gt[i][4] ? PBT_RD : PBT_WR, 2'h1, 2'h0, 13'h0000, 12);
            `CHK(ge_n, int'(gt[i][0]))
        end
        $display("test gaps done");
        @(negedge ref_clk);
        mpr_access = 1'b1;
        mr4(3'b001);
        `CHK({dqs_oe, dq_oe, dqs_t_o, dqs_c_o, dq_o}, 12'hDFF)
        @(negedge ref_clk);
        mpr_page = 2'h1;
        t_rises = 0;
        u_pbt_ctrl_model.issue(PBT_RD, 2'h0, 2'h0, 13'h0000, 20);
        `CHK(t_rises, 0)
        @(negedge ref_clk);
        mpr_page = 2'h0;
        u_pbt_ctrl_model.issue(PBT_RD, 2'h0, 2'h0, 13'h0000, 20);
        `CHK(t_rises, 4)
        mr4(3'b000);
        `CHK({dq_oe, dqs_oe}, 2'h0)
        $display("test training done");
        off = $urandom % 16;
        acc = 16'h0000;
        for (int k = 0; k < 32; k++)
        begin
            b = 4'(k + off);
            acc = (k < 16) ? acc | (16'h0001 << b) : acc & ~(16'h0001 << b);
            bank_q.push_back(acc);
            u_pbt_ctrl_model.issue(k < 16 ? PBT_ACT : PBT_PRE, b[3:2], b[1:0], 13'h0000, 4);
        end
        @(negedge ref_clk);
        org_x16 = 1'b1;
        bank_q.push_back(16'h0040);
        u_pbt_ctrl_model.issue(PBT_ACT, 2'h3, 2'h2, 13'h0000, 4);
        bank_q.push_back(16'h0000);
        u_pbt_ctrl_model.issue(PBT_PRE, 2'h3, 2'h2, 13'h0000, 8);
        $display("test banks done");
        `CHK(mode_q.size() + rd_q.size() + bank_q.size(), 0)
        summarize();
    end
endmodule // tb
